/* rtl/aoc_top.sv */
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module aoc_top import aoc_pkg::*; #(
  parameter logic [19:0] CYC_N = CYC_CYCLES,
  parameter logic [19:0] CONV_N = CONV_CYCLES,
  parameter logic [19:0] RAMP_N = RAMP_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [5:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Output word from communication unit
  input wire logic [15:0] fb_word_i,
  input wire logic fb_valid_i,
  input wire logic fb_invalid_i,
  // Current sense and DAC
  input wire logic [11:0] meas_code_i,
  output logic [11:0] dac_o,
  output logic out_en_o,
  // Status and identity
  output logic line_break_monitor_o,
  output logic stat_lb_o,
  output logic stat_inv_o,
  output logic [3:0] dig_o,
  output logic [7:0] cfg_id_o,
  output logic [7:0] in_bytes_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0] rate;
    logic [15:0] vmin;
    logic [15:0] vmax;
    logic [15:0] rs;
    logic [15:0] re;
    logic [7:0] psub;
    logic [7:0] psim;
    logic [2:0] ist;
    logic [2:0] ien;
    logic ack;
    logic [31:0] rdata;
    logic [19:0] cyc;
    logic [19:0] conv;
    logic [19:0] rtk;
    logic got;
    logic [1:0] fails;
    aoc_wd_t wd;
    logic [15:0] word;
    logic [15:0] last;
    logic [15:0] ramp;
    logic [11:0] dac;
    logic lb;
    logic stl;
    logic sti;
    logic [3:0] dig;
  } aoc_st_t;

  aoc_st_t s_q, s_d;
  logic req, cyc_end, conv_end, rtk_end, err, sim_inv, sim;
  logic [15:0] sub_code, sim_code, sel, tgt, step;
  logic [11:0] dac_map;
  aoc_err_t emode;

  // Linear percent to transfer code, saturated to 16 bits
  function automatic logic [15:0] pct2code(input logic [7:0] p,
      input logic [15:0] a, input logic [15:0] b);
    logic signed [33:0] v;
    v = 34'(signed'({1'b0, a})) + 34'(signed'(p)) *
        (34'(signed'({1'b0, b})) - 34'(signed'({1'b0, a}))) / 34'sd100;
    if (v < 34'sd0) return 16'h0000;
    else if (v > 34'sd65535) return 16'hFFFF;
    else return v[15:0];
  endfunction

  // Transfer code to DAC code, 4 to 20 mA across the range
  function automatic logic [11:0] code2dac(input logic [15:0] v,
      input logic [15:0] a, input logic [15:0] b, input logic lb_on);
    logic signed [33:0] d;
    d = 34'(DAC_4MA);
    if (b > a)
      d = d + (34'(signed'({1'b0, v})) - 34'(signed'({1'b0, a}))) *
          34'(signed'({1'b0, DAC_SPAN})) /
          (34'(signed'({1'b0, b})) - 34'(signed'({1'b0, a})));
    if (d < 34'sd0) d = 34'sd0;
    if (d > 34'(DAC_MAX)) d = 34'(DAC_MAX);
    if (lb_on && d < 34'(DAC_1MA)) d = 34'(DAC_1MA);
    return d[11:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Value path
  always_comb begin
    req = read_i | write_i;
    cyc_end = (s_q.cyc == CYC_N - 20'h00001);
    conv_end = (s_q.conv == CONV_N - 20'h00001);
    rtk_end = (s_q.rtk == RAMP_N - 20'h00001);
    emode = aoc_err_t'(s_q.ctrl[C_ERR +: 2]);
    sim = s_q.ctrl[C_SIM];
    sub_code = pct2code(s_q.psub, s_q.rs, s_q.re);
    sim_code = pct2code(s_q.psim, s_q.rs, s_q.re);
    sim_inv = sim & s_q.ctrl[C_SIM_INV];
    // Fault: missed exchange, invalid identifier or simulated invalid
    err = (s_q.fails != 2'h0) | fb_invalid_i | sim_inv;
    sel = sim ? sim_code : s_q.word;
    if (err) begin
      unique case (emode)
        ERR_SUBST: sel = sub_code;
        ERR_LAST: sel = s_q.last;
        default: sel = sel;
      endcase
    end
    // Clamp between software limits
    tgt = sel;
    if (tgt < s_q.vmin) tgt = s_q.vmin;
    if (tgt > s_q.vmax) tgt = s_q.vmax;
    // Ramp step per tick from percent of range per second
    step = 16'((32'(s_q.rate) * 32'(s_q.re - s_q.rs)) /
        32'(100 * RAMP_PER_S));
    if (step == 16'h0000) step = 16'h0001;
    dac_map = code2dac(s_q.ramp, s_q.rs, s_q.re, s_q.ctrl[C_LB]);
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.ack = req & ~s_q.ack;
    // Register writes take effect on the cycle waitrequest is low
    if (write_i && s_q.ack) begin
      unique case (address_i)
        A_CTRL: s_d.ctrl = writedata_i[15:0];
        A_RATE: s_d.rate = writedata_i[7:0];
        A_LIMIT: begin
          s_d.vmin = writedata_i[15:0];
          s_d.vmax = writedata_i[31:16];
        end
        A_RANGE: begin
          s_d.rs = writedata_i[15:0];
          s_d.re = writedata_i[31:16];
        end
        A_PCT: begin
          s_d.psub = writedata_i[7:0];
          s_d.psim = writedata_i[15:8];
        end
        A_IEN: s_d.ien = writedata_i[2:0];
        default: s_d.ien = s_q.ien;
      endcase
    end
    // Read data is captured as the answer is prepared
    s_d.rdata = 32'h00000000;
    if (read_i && !s_q.ack) begin
      unique case (address_i)
        A_CTRL: s_d.rdata = {16'h0000, s_q.ctrl};
        A_RATE: s_d.rdata = {24'h000000, s_q.rate};
        A_LIMIT: s_d.rdata = {s_q.vmax, s_q.vmin};
        A_RANGE: s_d.rdata = {s_q.re, s_q.rs};
        A_PCT: s_d.rdata = {16'h0000, s_q.psim, s_q.psub};
        A_STAT: s_d.rdata = {11'h000, s_q.fails, s_q.wd, s_q.sti,
            s_q.stl, s_q.lb, s_q.dac, 3'h0};
        A_IST: s_d.rdata = {29'h00000000, s_q.ist};
        A_IEN: s_d.rdata = {29'h00000000, s_q.ien};
        A_ID: s_d.rdata = {16'h0000, IN_BYTES, CFG_ID};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    // Clear first, events then win over a same-cycle clear
    if (write_i && s_q.ack && address_i == A_ICLR)
      s_d.ist = s_q.ist & ~writedata_i[2:0];
    // Fieldbus word: 12-bit value in the top, digital nibble below
    if (fb_valid_i) begin
      s_d.word = {fb_word_i[15:4], 4'h0};
      s_d.dig = fb_word_i[3:0];
      s_d.got = 1'b1;
    end
    // Exchange cycle watchdog
    s_d.cyc = cyc_end ? 20'h00000 : s_q.cyc + 20'h00001;
    if (cyc_end) begin
      s_d.got = fb_valid_i;
      if (s_q.got || fb_valid_i) begin
        s_d.fails = 2'h0;
        s_d.wd = WD_RUN;
      end else begin
        s_d.ist[I_FAIL] = 1'b1;
        if (s_q.fails != FAIL_LIMIT) s_d.fails = s_q.fails + 2'h1;
        if (s_q.fails == FAIL_LIMIT - 2'h1) begin
          s_d.wd = WD_OFF;
          s_d.ist[I_OFF] = 1'b1;
        end
      end
    end
    // Remember the last value taken without a fault
    if (!err) s_d.last = sel;
    // Ramp toward the clamped target
    s_d.rtk = rtk_end ? 20'h00000 : s_q.rtk + 20'h00001;
    if (s_q.rate == 8'h00) s_d.ramp = tgt;
    else if (rtk_end) begin
      if (tgt > s_q.ramp)
        s_d.ramp = (tgt - s_q.ramp > step) ? s_q.ramp + step : tgt;
      else
        s_d.ramp = (s_q.ramp - tgt > step) ? s_q.ramp - step : tgt;
    end
    // Conversion tick updates DAC and status flags
    s_d.conv = conv_end ? 20'h00000 : s_q.conv + 20'h00001;
    if (conv_end) begin
      s_d.dac = dac_map;
      s_d.stl = 1'b0;
      s_d.sti = 1'b0;
      if (sim) begin
        s_d.stl = s_q.ctrl[C_SIM_LB];
        s_d.sti = s_q.ctrl[C_SIM_INV];
      end
      if (err && emode == ERR_SUBST && s_q.ctrl[C_SUBST]) begin
        s_d.stl = s_q.ctrl[C_SUB_LB];
        s_d.sti = s_q.ctrl[C_SUB_INV];
      end
    end
    // Lead break: only open line, never shorts
    s_d.lb = s_q.ctrl[C_LB] && s_q.wd == WD_RUN &&
        meas_code_i < DAC_BREAK;
    if (s_d.lb) s_d.ist[I_BREAK] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.ctrl <= RST_CTRL;
      s_q.vmin <= RST_MIN;
      s_q.vmax <= RST_MAX;
      s_q.rs <= RST_START;
      s_q.re <= RST_END;
      s_q.wd <= WD_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign waitrequest_o = req & ~s_q.ack;
  assign readdata_o = s_q.rdata;
  assign dac_o = (s_q.wd == WD_OFF) ? 12'h000 : s_q.dac;
  assign out_en_o = (s_q.wd == WD_RUN);
  assign line_break_monitor_o = s_q.lb;
  assign stat_lb_o = s_q.stl;
  assign stat_inv_o = s_q.sti;
  assign dig_o = s_q.dig;
  assign cfg_id_o = CFG_ID;
  assign in_bytes_o = IN_BYTES;
  assign irq_o = |(s_q.ist & s_q.ien);

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  property p_wd_off;
    (s_q.fails == 2'h2 && cyc_end && !s_q.got && !fb_valid_i) |=>
      (dac_o == 12'h000 && !out_en_o)[*3];
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("output not off after three failed exchanges");

  property p_min_cur;
    (conv_end && s_q.ctrl[C_LB] && s_q.wd == WD_RUN) |=>
      (!out_en_o || dac_o >= DAC_1MA);
  endproperty
  a_min_cur: assert property (p_min_cur)
    else $error("current below 1 mA with monitor on");

  property p_ramp_bypass;
    (s_q.rate == 8'h00 && !write_i) |=> s_q.ramp == $past(tgt);
  endproperty
  a_ramp_bypass: assert property (p_ramp_bypass)
    else $error("ramp active with rate zero");

  property p_clamp;
    (s_q.vmin <= s_q.vmax && s_q.rate == 8'h00 && !write_i) |=>
      (s_q.ramp >= s_q.vmin && s_q.ramp <= s_q.vmax);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("target outside limits");

  property p_break;
    (s_q.ctrl[C_LB] && out_en_o && meas_code_i < DAC_BREAK) |=>
      line_break_monitor_o ##1 irq_o || !s_q.ien[I_BREAK];
  endproperty
  a_break: assert property (p_break)
    else $error("lead break not flagged");

  property p_sim_inv;
    (sim && s_q.ctrl[C_SIM_INV] && emode == ERR_SUBST) |-> sel == sub_code;
  endproperty
  a_sim_inv: assert property (p_sim_inv)
    else $error("simulated invalid did not select substitute");

  property p_unpack;
    fb_valid_i |=> {s_q.word[15:4], dig_o} == $past(fb_word_i) &&
      s_q.word[3:0] == 4'h0;
  endproperty
  a_unpack: assert property (p_unpack)
    else $error("output word unpacked wrongly");

  property p_ident;
    cfg_id_o == 8'h3C && in_bytes_o == 8'h00;
  endproperty
  a_ident: assert property (p_ident)
    else $error("identity code wrong");

  property p_last;
    (err && emode == ERR_LAST && !fb_valid_i) |=> $stable(s_q.last);
  endproperty
  a_last: assert property (p_last)
    else $error("last valid value changed during fault");

  property p_zero_pct;
    (conv_end && !s_q.ctrl[C_LB] && s_q.ramp == s_q.rs &&
      s_q.re > s_q.rs) |=> s_q.dac == DAC_4MA;
  endproperty
  a_zero_pct: assert property (p_zero_pct)
    else $error("zero percent not 4 mA");

  property p_sub_flags;
    (conv_end && err && emode == ERR_SUBST && s_q.ctrl[C_SUBST] &&
      !write_i) |=>
      stat_lb_o == s_q.ctrl[C_SUB_LB] && stat_inv_o == s_q.ctrl[C_SUB_INV];
  endproperty
  a_sub_flags: assert property (p_sub_flags)
    else $error("substitute status flags wrong");

  property p_sim_flags;
    (conv_end && sim && !write_i &&
      !(err && emode == ERR_SUBST && s_q.ctrl[C_SUBST])) |=>
      stat_lb_o == s_q.ctrl[C_SIM_LB] &&
      stat_inv_o == s_q.ctrl[C_SIM_INV];
  endproperty
  a_sim_flags: assert property (p_sim_flags)
    else $error("simulation status flags wrong");

  property p_no_short;
    (!s_q.ctrl[C_LB] || meas_code_i >= DAC_BREAK) |=>
      !line_break_monitor_o;
  endproperty
  a_no_short: assert property (p_no_short)
    else $error("lead break flagged without open line");

  property p_fail_flag;
    (cyc_end && !s_q.got && !fb_valid_i) |=> s_q.ist[I_FAIL];
  endproperty
  a_fail_flag: assert property (p_fail_flag)
    else $error("missed exchange not flagged");

  property p_sub_zero;
    (s_q.psub == 8'h00) |-> sub_code == s_q.rs;
  endproperty
  a_sub_zero: assert property (p_sub_zero)
    else $error("zero percent substitute not start of range");

  c_wd: cover property (s_q.wd == WD_RUN ##1 s_q.wd == WD_OFF);
  c_sim: cover property (sim && conv_end);
  c_sub: cover property (err && emode == ERR_SUBST && conv_end);
  c_irq: cover property ($rose(irq_o));
endmodule // aoc_top
`default_nettype wire

/* rtl/aoc_pkg.sv */
// Function
// - Ramp limits value change to rate percent of range per second; 0 disables
// - Transferred value is clamped between min and max limits, 0 to 65535
// - On error with substitute strategy, output the substitute percent value
// - Substitute value may carry lead-break and invalid-data flags
// - Simulation mode outputs simulation percent value with optional flags
// - Simulation invalid-data flag starts the substitute-value error strategy; here it raises a fault and the error strategy selected in ctrl applies
// - Output current spans 0 to 26.2 mA with a 12-bit DAC code
// - 0 to 100 percent maps onto 4 to 20 mA in 2500 steps
// - Words exchanged every 6.5 ms; conversion runs every 50 ms
// - Process data is an unsigned 16-bit integer without sign
// - Upper 12 bits of output word hold value; low nibble is digital
// - No input bytes; configuration identifier code is 60
// - Lead-break monitor can be enabled; short circuits are not detected
// - With monitor enabled at least 1 mA is always driven; here dac_o is forced to 0 while the watchdog is in WD_OFF
// - Lead break is flagged when measured current is below 0.1 mA
// - On fault output current value, substitute value or last valid value
// - Three failed exchanges switch the output off within 500 ms
`default_nettype none
package aoc_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_KHZ = 10000;
  localparam int T_CYC_US = 6500;
  localparam int T_CONV_MS = 50;
  localparam int T_RAMP_MS = 10;
  localparam logic [19:0] CYC_CYCLES = 20'(T_CYC_US * CLK_KHZ / 1000);
  localparam logic [19:0] CONV_CYCLES = 20'(T_CONV_MS * CLK_KHZ);
  localparam logic [19:0] RAMP_CYCLES = 20'(T_RAMP_MS * CLK_KHZ);
  localparam int RAMP_PER_S = 1000 / T_RAMP_MS;
  localparam logic [1:0] FAIL_LIMIT = 2'h3;
  ////////////////////////////////////////////////////////////////////////
  // Output scaling, 156.25 codes per mA
  localparam logic [11:0] DAC_MAX = 12'hFFF;
  localparam logic [11:0] DAC_4MA = 12'h271;
  localparam logic [11:0] DAC_SPAN = 12'h9C4;
  localparam logic [11:0] DAC_1MA = 12'h09D;
  localparam logic [11:0] DAC_BREAK = 12'h00F;
  localparam logic [7:0] CFG_ID = 8'h3C;
  localparam logic [7:0] IN_BYTES = 8'h00;
  ////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_RATE = 6'h04;
  localparam logic [5:0] A_LIMIT = 6'h08;
  localparam logic [5:0] A_RANGE = 6'h0C;
  localparam logic [5:0] A_PCT = 6'h10;
  localparam logic [5:0] A_STAT = 6'h14;
  localparam logic [5:0] A_IST = 6'h18;
  localparam logic [5:0] A_ICLR = 6'h1C;
  localparam logic [5:0] A_IEN = 6'h20;
  localparam logic [5:0] A_ID = 6'h24;
  // Control fields
  localparam int C_SIM = 0;
  localparam int C_ERR = 1;
  localparam int C_LB = 3;
  localparam int C_SUBST = 4;
  localparam int C_SUB_LB = 5;
  localparam int C_SUB_INV = 6;
  localparam int C_SIM_LB = 7;
  localparam int C_SIM_INV = 8;
  // Interrupt bits
  localparam int I_BREAK = 0;
  localparam int I_FAIL = 1;
  localparam int I_OFF = 2;
  // Reset values
  localparam logic [15:0] RST_START = 16'h2710;
  localparam logic [15:0] RST_END = 16'hC350;
  localparam logic [15:0] RST_MIN = 16'h0000;
  localparam logic [15:0] RST_MAX = 16'hFFFF;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  ////////////////////////////////////////////////////////////////////////
  // Error strategies and watchdog states
  typedef enum logic [1:0] {
    ERR_CURRENT = 2'b00,
    ERR_SUBST = 2'b01,
    ERR_LAST = 2'b10
  } aoc_err_t;
  typedef enum logic {
    WD_RUN = 1'b0,
    WD_OFF = 1'b1
  } aoc_wd_t;
endpackage
`default_nettype wire

/* dv/aoc_fb_model.sv */
`timescale 1ns/1ns
`default_nettype none
module aoc_fb_model #(
  parameter int PERIOD = 10
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Control from the bench
  input wire logic run_i,
  input wire logic [15:0] word_i,
  // Output word towards the channel
  output logic [15:0] fb_word_o,
  output logic fb_valid_o
);
  int cnt;
  logic [15:0] last;
  ////////////////////////////////////////////////////////////////////////
  // One word per period while running; between words the bus shows junk
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 0;
      fb_valid_o <= 1'b0;
      fb_word_o <= 16'h0000;
      last <= 16'h0000;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      fb_valid_o <= run_i && cnt == 0;
      if (run_i && cnt == 0) begin
        fb_word_o <= word_i;
        last <= word_i;
      end else begin
        fb_word_o <= ~last;
      end
    end
  end
endmodule // aoc_fb_model
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench import aoc_pkg::*;;
  logic mclk_i = 1'b0;
  logic sys_rst_i, read_i, write_i, fb_valid_i, fb_invalid_i, run;
  logic [5:0] address_i;
  logic [31:0] writedata_i, readdata_o;
  logic [15:0] fb_word_i, word, w;
  logic [11:0] meas_code_i, dac_o;
  logic waitrequest_o, out_en_o, line_break_monitor_o, irq_o;
  logic stat_lb_o, stat_inv_o;
  logic [3:0] dig_o;
  logic [7:0] cfg_id_o, in_bytes_o;
  logic [31:0] exp_q [$];
  logic [15:0] vals [5] = '{16'h2710, 16'h7530, 16'hC350, 16'h0000,
                            16'hFFF0};
  int mismatches, check_count, cycles;
  ////////////////////////////////////////////////////////////////////////
  // Clock, design and far-side model
  always #50 mclk_i = ~mclk_i;
  aoc_top #(.CYC_N(20'd20), .CONV_N(20'd8), .RAMP_N(20'd4)) u_aoc_top (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .fb_word_i(fb_word_i), .fb_valid_i(fb_valid_i),
    .fb_invalid_i(fb_invalid_i), .meas_code_i(meas_code_i),
    .dac_o(dac_o), .out_en_o(out_en_o),
    .line_break_monitor_o(line_break_monitor_o), .stat_lb_o(stat_lb_o),
    .stat_inv_o(stat_inv_o), .dig_o(dig_o), .cfg_id_o(cfg_id_o),
    .in_bytes_o(in_bytes_o), .irq_o(irq_o));
  aoc_fb_model #(.PERIOD(10)) u_aoc_fb_model (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .run_i(run), .word_i(word),
    .fb_word_o(fb_word_i), .fb_valid_o(fb_valid_i));
  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Avalon cycle; a read notes its expected data for the monitor
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    address_i <= a;
    writedata_i <= d;
    read_i <= !wr;
    write_i <= wr;
    if (!wr) exp_q.push_back(d);
    do @(posedge mclk_i); while (waitrequest_o !== 1'b0);
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  function automatic logic [11:0] exp_dac(input int v);
    int e;
    e = int'(DAC_4MA) + (v - int'(RST_START)) * int'(DAC_SPAN) /
        int'(RST_END - RST_START);
    if (e < 0) e = 0;
    if (e > int'(DAC_MAX)) e = int'(DAC_MAX);
    return 12'(e);
  endfunction
  function automatic int pct(input int p);
    return int'(RST_START) + p * int'(RST_END - RST_START) / 100;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Read monitor takes the oldest note when read data stands
  always @(posedge mclk_i) begin
    if (read_i && waitrequest_o === 1'b0 && exp_q.size() > 0)
      cmp(readdata_o, exp_q.pop_front());
  end
  // Hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    mismatches = 0;
    check_count = 0;
    cycles = 0;
    sys_rst_i = 1'b1;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = 6'h00;
    writedata_i = 32'h0;
    fb_invalid_i = 1'b0;
    meas_code_i = 12'h200;
    run = 1'b0;
    word = 16'h2710;
    void'($urandom(32'h1B6A94F6));
    cyc(16);
    sys_rst_i <= 1'b0;
    run <= 1'b1;
    // Reset values, identity, unmapped and read-only places
    cmp(cfg_id_o, CFG_ID);
    cmp(in_bytes_o, IN_BYTES);
    bus(0, A_ID, {16'h0000, IN_BYTES, CFG_ID});
    bus(0, A_LIMIT, {RST_MAX, RST_MIN});
    bus(0, A_RANGE, {RST_END, RST_START});
    bus(0, A_CTRL, 32'h0);
    bus(0, 6'h3C, 32'h0);
    bus(1, A_IST, 32'h7);
    bus(0, A_IST, 32'h0);
    bus(0, A_ICLR, 32'h0);
    bus(1, A_RATE, 32'h0);
    $display("test reset done");
    // Normal path across the range, random digital nibble
    for (int i = 0; i < 5; i++) begin
      w = {vals[i][15:4], 4'($urandom)};
      word <= w;
      cyc(40);
      cmp(dac_o, exp_dac(int'(vals[i])));
      cmp(dig_o, w[3:0]);
    end
    $display("test scaling done");
    // Clamping to min and max
    bus(1, A_LIMIT, {16'h9C40, 16'h4E20});
    word <= 16'h0000;
    cyc(40);
    cmp(dac_o, exp_dac(20000));
    word <= 16'hFFF0;
    cyc(40);
    cmp(dac_o, exp_dac(40000));
    bus(1, A_LIMIT, {RST_MAX, RST_MIN});
    $display("test clamp done");
    // Line break monitor, floor current and interrupt
    bus(1, A_CTRL, 32'h8);
    word <= 16'h0000;
    cyc(40);
    cmp(dac_o, DAC_1MA);
    meas_code_i <= 12'h00E;
    cyc(40);
    cmp(line_break_monitor_o, 1'b1);
    bus(0, A_IST, 32'h1);
    cmp(irq_o, 1'b0);
    bus(1, A_IEN, 32'h1);
    cyc(2);
    cmp(irq_o, 1'b1);
    meas_code_i <= 12'h200;
    cyc(20);
    bus(1, A_ICLR, 32'h1);
    cyc(2);
    bus(0, A_IST, 32'h0);
    cmp(irq_o, 1'b0);
    $display("test break done");
    // Substitute value with flags under an invalid identifier
    bus(1, A_PCT, 32'h3219);
    bus(1, A_CTRL, 32'h72);
    word <= 16'h7530;
    fb_invalid_i <= 1'b1;
    cyc(40);
    cmp(dac_o, exp_dac(pct(25)));
    cmp({stat_lb_o, stat_inv_o}, 2'b11);
    foreach (vals[i]) begin
      if (i < 2) begin
        bus(1, A_PCT, {24'h000032, 8'(i == 0 ? -25 : 125)});
        cyc(40);
        cmp(dac_o, exp_dac(pct(i == 0 ? -25 : 125)));
      end
    end
    fb_invalid_i <= 1'b0;
    $display("test substitute done");
    // Simulation value, its flags, and invalid flag starting substitute
    bus(1, A_PCT, 32'h3219);
    bus(1, A_CTRL, 32'h181);
    cyc(40);
    cmp(dac_o, exp_dac(pct(50)));
    cmp({stat_lb_o, stat_inv_o}, 2'b11);
    bus(1, A_CTRL, 32'h103);
    cyc(40);
    cmp(dac_o, exp_dac(pct(25)));
    $display("test simulation done");
    // Last valid value
    bus(1, A_CTRL, 32'h4);
    cyc(40);
    fb_invalid_i <= 1'b1;
    word <= 16'hC350;
    cyc(40);
    cmp(dac_o, exp_dac(30000));
    fb_invalid_i <= 1'b0;
    cyc(40);
    cmp(dac_o, exp_dac(50000));
    $display("test last valid done");
    // Ramp at 100 percent per second, then off
    bus(1, A_RATE, 32'h64);
    word <= 16'h2710;
    cyc(40);
    cmp(dac_o > exp_dac(10000) && dac_o < exp_dac(50000), 1'b1);
    cyc(600);
    cmp(dac_o, exp_dac(10000));
    bus(1, A_RATE, 32'h0);
    $display("test ramp done");
    // Watchdog after three missed exchanges, then a second reset
    bus(1, A_IEN, 32'h6);
    run <= 1'b0;
    cyc(30);
    cmp(out_en_o, 1'b1);
    cyc(60);
    cmp({out_en_o, dac_o}, 13'h0000);
    cmp(irq_o, 1'b1);
    bus(0, A_IST, 32'h6);
    sys_rst_i <= 1'b1;
    cyc(2);
    cmp({out_en_o, dac_o}, 13'h1000);
    sys_rst_i <= 1'b0;
    run <= 1'b1;
    bus(0, A_IST, 32'h0);
    $display("test watchdog done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
